// *** design/ptkts_top.sv ***
// local and per-port network time keepers with frame and trigger stamping
// assumes host and protocol firmware commands are on core_clk; ref, trigger
// and frame-start pins are asynchronous and pass two flops first
`timescale 1ns/1ps
module ptkts_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // backplane reference and trigger lines (pins)
    input wire logic backplane_ref_clock,
    input wire logic [ptkts_pkg::NUM_TRIG-1:0] trig_in,
    // frame start strobes from the phy side (pins)
    input wire logic [ptkts_pkg::NUM_PORTS-1:0] rx_frame_start,
    input wire logic [ptkts_pkg::NUM_PORTS-1:0] tx_frame_start,
    // port configuration
    input wire logic [ptkts_pkg::NUM_PORTS-1:0] monitor_en,
    input wire logic [ptkts_pkg::NUM_PORTS-1:0] port_master,
    // time commands from host software and from the sync firmware
    input wire ptkts_pkg::ptkts_cmd_type local_cmd,
    input wire ptkts_pkg::ptkts_cmd_type [ptkts_pkg::NUM_PORTS-1:0] net_cmd,
    input wire ptkts_pkg::ptkts_cmd_type [ptkts_pkg::NUM_PORTS-1:0] gm_cmd,
    // time and reference status
    output logic ref_present_q,
    output logic [ptkts_pkg::TIME_W-1:0] local_time_ns,
    output logic [ptkts_pkg::NUM_PORTS-1:0][ptkts_pkg::TIME_W-1:0] net_time_ns,
    // timestamps
    output ptkts_pkg::ptkts_stamp_type [ptkts_pkg::NUM_PORTS-1:0] port_stamp_q,
    output ptkts_pkg::ptkts_trig_type trig_stamp_q
);
    logic ref_rise;
    logic [ptkts_pkg::NUM_TRIG-1:0] trig_rise;
    logic [ptkts_pkg::NUM_PORTS-1:0] rx_rise;
    logic [ptkts_pkg::NUM_PORTS-1:0] tx_rise;
    logic [ptkts_pkg::GAP_W-1:0] gap_q;
    logic [ptkts_pkg::GAP_W-1:0] gap_d;
    logic ref_present_d;
    logic gap_expired;
    logic local_tick;
    logic [ptkts_pkg::TIME_W-1:0] local_inc;
    ptkts_pkg::ptkts_trig_type trig_stamp_d;

    // synchronisers: reference, triggers and frame strobes
    ptkts_edge_sync #(.W(1)) u_ref_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(backplane_ref_clock),
        .level_q(),
        .rise(ref_rise)
    );

    ptkts_edge_sync #(.W(ptkts_pkg::NUM_TRIG)) u_trig_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(trig_in),
        .level_q(),
        .rise(trig_rise)
    );

    // frame strobes come straight from the phy pins, not from the mac, to keep
    // the stamp latency a fixed two-flop delay
    ptkts_edge_sync #(.W(ptkts_pkg::NUM_PORTS)) u_rx_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(rx_frame_start),
        .level_q(),
        .rise(rx_rise)
    );

    ptkts_edge_sync #(.W(ptkts_pkg::NUM_PORTS)) u_tx_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(tx_frame_start),
        .level_q(),
        .rise(tx_rise)
    );

    // reference presence: a gap longer than the loss time drops to the oscillator
    assign gap_expired = (gap_q == ptkts_pkg::REF_LOSS_CYC - 4'h1);
    assign gap_d = ref_rise ? '0 : (gap_expired ? gap_q : gap_q + 4'h1);
    assign ref_present_d = ref_rise ? 1'b1 : (gap_expired ? 1'b0 : ref_present_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_q <= '0;
            ref_present_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            ref_present_q <= ref_present_d;
        end
    end

    // source select: a switch mid-period may slip one increment, traded for
    // having no second clock domain at all
    assign local_tick = ref_present_q ? ref_rise : 1'b1;
    assign local_inc = ref_present_q ? ptkts_pkg::REF_INC_NS : ptkts_pkg::INT_INC_NS;

    // local time keeper, loaded and adjusted by host software
    ptkts_time_keeper u_local (
        .core_clk(core_clk),
        .rst(rst),
        .tick(local_tick),
        .inc(local_inc),
        .load_valid(local_cmd.load),
        .load_value(local_cmd.value),
        .adj_valid(local_cmd.adjust & ~local_cmd.load),
        .adj_delta(local_cmd.value),
        .time_q(local_time_ns)
    );

    // one network time keeper per port
    for (genvar p = 0; p < ptkts_pkg::NUM_PORTS; p++) begin : g_port
        logic net_tick;
        logic [ptkts_pkg::TIME_W-1:0] net_inc;
        logic net_load;
        logic [ptkts_pkg::TIME_W-1:0] net_load_value;
        logic host_adj;
        logic gm_adj;
        logic net_adj;
        logic [ptkts_pkg::TIME_W-1:0] net_adj_delta;
        ptkts_pkg::ptkts_stamp_type stamp_d;

        // master follows the local tick; slave free-runs and may drift
        assign net_tick = port_master[p] ? local_tick : 1'b1;
        assign net_inc = port_master[p] ? local_inc : ptkts_pkg::INT_INC_NS;
        // master loads from host time, slave from the grandmaster
        assign net_load = port_master[p] ? net_cmd[p].load : gm_cmd[p].load;
        assign net_load_value = port_master[p] ? net_cmd[p].value : gm_cmd[p].value;
        // host adjusts any port; firmware corrections apply to slaves only
        assign host_adj = net_cmd[p].adjust & ~net_cmd[p].load;
        assign gm_adj = ~port_master[p] & gm_cmd[p].adjust & ~gm_cmd[p].load;
        assign net_adj = host_adj | gm_adj;
        assign net_adj_delta = (host_adj ? net_cmd[p].value : '0) + (gm_adj ? gm_cmd[p].value : '0);

        ptkts_time_keeper u_net (
            .core_clk(core_clk),
            .rst(rst),
            .tick(net_tick),
            .inc(net_inc),
            .load_valid(net_load),
            .load_value(net_load_value),
            .adj_valid(net_adj),
            .adj_delta(net_adj_delta),
            .time_q(net_time_ns[p])
        );

        // received frames always flagged, transmitted ones only when monitored; both edges capture the times
        assign stamp_d.rx_valid = rx_rise[p];
        assign stamp_d.tx_valid = tx_rise[p] & monitor_en[p];
        assign stamp_d.local_ns = (rx_rise[p] | tx_rise[p]) ? local_time_ns : port_stamp_q[p].local_ns;
        assign stamp_d.net_ns = (rx_rise[p] | tx_rise[p]) ? net_time_ns[p] : port_stamp_q[p].net_ns;

        // stamp pair captured in the same cycle from both keepers
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                port_stamp_q[p] <= '0;
            end else begin
                port_stamp_q[p] <= stamp_d;
            end
        end

        a_rx_stamp: assert property (@(posedge core_clk) disable iff (rst)
            rx_rise[p] |=> port_stamp_q[p].rx_valid && port_stamp_q[p].local_ns == $past(local_time_ns)
                && port_stamp_q[p].net_ns == $past(net_time_ns[p]))
            else $error("received frame stamp missing or wrong");

        a_tx_monitor: assert property (@(posedge core_clk) disable iff (rst)
            tx_rise[p] |=> port_stamp_q[p].tx_valid == $past(monitor_en[p]))
            else $error("transmit stamp does not follow the monitor enable");

        a_master_lock: assert property (@(posedge core_clk) disable iff (rst)
            (port_master[p] && !net_cmd[p].load && !net_cmd[p].adjust)
            |=> net_time_ns[p] == $past(net_time_ns[p]) + ($past(local_tick) ? $past(local_inc) : 64'h0))
            else $error("master port not advancing with local time");

        a_slave_gm: assert property (@(posedge core_clk) disable iff (rst)
            (!port_master[p] && gm_cmd[p].load) |=> net_time_ns[p] == $past(gm_cmd[p].value))
            else $error("slave port did not take grandmaster time");

        // stamps hold between edges; slaves free-run; host commands per port
        a_stamp_hold: assert property (@(posedge core_clk) disable iff (rst)
            !(rx_rise[p] || tx_rise[p])
            |=> !port_stamp_q[p].rx_valid && !port_stamp_q[p].tx_valid
                && $stable(port_stamp_q[p].local_ns) && $stable(port_stamp_q[p].net_ns))
            else $error("frame stamp changed without a frame edge");

        a_rx_only: assert property (@(posedge core_clk) disable iff (rst)
            (rx_rise[p] && !tx_rise[p]) |=> !port_stamp_q[p].tx_valid)
            else $error("received frame flagged as transmitted");

        a_tx_stamp: assert property (@(posedge core_clk) disable iff (rst)
            (tx_rise[p] && monitor_en[p]) |=> port_stamp_q[p].tx_valid
                && port_stamp_q[p].local_ns == $past(local_time_ns)
                && port_stamp_q[p].net_ns == $past(net_time_ns[p]))
            else $error("monitored transmit frame stamp missing or wrong");

        a_slave_free: assert property (@(posedge core_clk) disable iff (rst)
            (!port_master[p] && !gm_cmd[p].load && !gm_cmd[p].adjust && !net_cmd[p].adjust)
            |=> net_time_ns[p] == $past(net_time_ns[p]) + ptkts_pkg::INT_INC_NS)
            else $error("slave port not free-running on the oscillator");

        a_master_load: assert property (@(posedge core_clk) disable iff (rst)
            (port_master[p] && net_cmd[p].load) |=> net_time_ns[p] == $past(net_cmd[p].value))
            else $error("master port did not take host time");

        a_host_net_adj: assert property (@(posedge core_clk) disable iff (rst)
            (port_master[p] && net_cmd[p].adjust && !net_cmd[p].load)
            |=> net_time_ns[p] == $past(net_time_ns[p]) + $past(net_cmd[p].value)
                + ($past(local_tick) ? $past(local_inc) : 64'h0))
            else $error("host adjustment of a master port lost");
    end

    // trigger stamps: simultaneous edges share one capture
    assign trig_stamp_d.mask = trig_rise;
    assign trig_stamp_d.local_ns = (|trig_rise) ? local_time_ns : trig_stamp_q.local_ns;
    assign trig_stamp_d.net_ns = (|trig_rise) ? net_time_ns : trig_stamp_q.net_ns;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_stamp_q <= '0;
        end else begin
            trig_stamp_q <= trig_stamp_d;
        end
    end

    a_ref_tick: assert property (@(posedge core_clk) disable iff (rst)
        (ref_present_q && ref_rise && !local_cmd.load && !local_cmd.adjust)
        |=> local_time_ns == $past(local_time_ns) + ptkts_pkg::REF_INC_NS)
        else $error("local time not advanced by one reference period");

    a_ref_hold: assert property (@(posedge core_clk) disable iff (rst)
        (ref_present_q && !ref_rise && !local_cmd.load && !local_cmd.adjust)
        |=> local_time_ns == $past(local_time_ns))
        else $error("local time moved between reference edges");

    a_int_osc: assert property (@(posedge core_clk) disable iff (rst)
        (!ref_present_q && !local_cmd.load && !local_cmd.adjust)
        |=> local_time_ns == $past(local_time_ns) + ptkts_pkg::INT_INC_NS)
        else $error("oscillator fallback not advancing local time");

    a_ref_loss: assert property (@(posedge core_clk) disable iff (rst)
        (ref_present_q && gap_expired && !ref_rise) |=> !ref_present_q)
        else $error("reference loss not detected");

    a_ref_found: assert property (@(posedge core_clk) disable iff (rst)
        $rose(ref_present_q) |-> $past(ref_rise))
        else $error("reference declared present without an edge");

    a_trig_stamp: assert property (@(posedge core_clk) disable iff (rst)
        (|trig_rise) |=> trig_stamp_q.mask == $past(trig_rise) && trig_stamp_q.local_ns == $past(local_time_ns)
            && trig_stamp_q.net_ns == $past(net_time_ns))
        else $error("trigger stamp wrong");

    // host commands on the local keeper, trigger stamp hold and the presence tracker
    a_local_load: assert property (@(posedge core_clk) disable iff (rst)
        local_cmd.load |=> local_time_ns == $past(local_cmd.value))
        else $error("local time did not take the host load");

    a_local_adjust: assert property (@(posedge core_clk) disable iff (rst)
        (local_cmd.adjust && !local_cmd.load)
        |=> local_time_ns == $past(local_time_ns) + $past(local_cmd.value)
            + ($past(local_tick) ? $past(local_inc) : 64'h0))
        else $error("host adjustment of local time lost");

    a_trig_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(|trig_rise) |=> trig_stamp_q.mask == '0
            && $stable(trig_stamp_q.local_ns) && $stable(trig_stamp_q.net_ns))
        else $error("trigger stamp changed without a trigger edge");

    a_ref_keep: assert property (@(posedge core_clk) disable iff (rst)
        (ref_present_q && !gap_expired) |=> ref_present_q)
        else $error("reference dropped before the loss time");

    a_presence_hold: assert property (@(posedge core_clk) disable iff (rst)
        (!ref_present_q && !ref_rise) |=> !ref_present_q)
        else $error("reference declared present with no edge");

    a_gap_restart: assert property (@(posedge core_clk) disable iff (rst)
        ref_rise |=> gap_q == 4'h0 && ref_present_q)
        else $error("reference edge did not restart the gap count");

    a_gap_count: assert property (@(posedge core_clk) disable iff (rst)
        (!ref_rise && !gap_expired) |=> gap_q == $past(gap_q) + 4'h1)
        else $error("gap counter did not advance");

    c_ref_lost: cover property (@(posedge core_clk) disable iff (rst) $fell(ref_present_q));
    c_trig_multi: cover property (@(posedge core_clk) disable iff (rst) $countones(trig_rise) > 1);
    c_tx_monitored: cover property (@(posedge core_clk) disable iff (rst) port_stamp_q[0].tx_valid);
    c_rx_tx_same: cover property (@(posedge core_clk) disable iff (rst)
        port_stamp_q[1].rx_valid && port_stamp_q[1].tx_valid);
    c_slave_gm_load: cover property (@(posedge core_clk) disable iff (rst) !port_master[1] && gm_cmd[1].load);
endmodule

// *** inc/ptkts_pkg.sv ***
// constants and carrier types for the port time keeper and timestamp block
// assumes one 25 MHz core clock; all widths are fixed
package ptkts_pkg;

    // sizes
    localparam int NUM_PORTS = 4;
    localparam int NUM_TRIG = 8;
    localparam int TIME_W = 64;

    // clock rates and derived nanosecond increments
    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_FREQ_MHZ = 10;
    localparam int REF_PERIOD_NS = 1000 / REF_FREQ_MHZ;
    localparam logic [TIME_W-1:0] REF_INC_NS = TIME_W'(REF_PERIOD_NS);
    localparam logic [TIME_W-1:0] INT_INC_NS = TIME_W'(CLK_PERIOD_NS);

    // reference loss: longest gap, rounded down to whole cycles, at least one
    localparam int REF_LOSS_NS = 400;
    localparam int REF_LOSS_CYC_I = (REF_LOSS_NS / CLK_PERIOD_NS) < 1 ? 1 : (REF_LOSS_NS / CLK_PERIOD_NS);
    localparam int GAP_W = 4;
    localparam logic [GAP_W-1:0] REF_LOSS_CYC = GAP_W'(REF_LOSS_CYC_I);

    // reset values
    localparam logic [TIME_W-1:0] TIME_RESET = 64'h0000_0000_0000_0000;

    // time command: load wins over adjust; value is the new time or a signed delta
    typedef struct packed {
        logic load;
        logic adjust;
        logic [TIME_W-1:0] value;
    } ptkts_cmd_type;

    // one frame timestamp pair
    typedef struct packed {
        logic rx_valid;
        logic tx_valid;
        logic [TIME_W-1:0] local_ns;
        logic [TIME_W-1:0] net_ns;
    } ptkts_stamp_type;

    // one trigger timestamp set: local time plus every port's network time
    typedef struct packed {
        logic [NUM_TRIG-1:0] mask;
        logic [TIME_W-1:0] local_ns;
        logic [NUM_PORTS-1:0][TIME_W-1:0] net_ns;
    } ptkts_trig_type;

endpackage

// *** design/ptkts_edge_sync.sv ***
// two-flop synchroniser with rising-edge detect for a group of pins
// assumes the pins are asynchronous to core_clk and held at least two cycles
`timescale 1ns/1ps
module ptkts_edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pins and detected edges
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_q,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta_q;
    logic [W-1:0] prev_q;

    // first flop feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            level_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_in;
            level_q <= meta_q;
            prev_q <= level_q;
        end
    end

    // edge seen on the settled copy only
    assign rise = level_q & ~prev_q;
endmodule

// *** design/ptkts_time_keeper.sv ***
// one nanosecond time keeper: tick increment, software load and adjust
// assumes tick, inc and commands come from logic on core_clk
`timescale 1ns/1ps
module ptkts_time_keeper (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // advance
    input wire logic tick,
    input wire logic [ptkts_pkg::TIME_W-1:0] inc,
    // load and adjust
    input wire logic load_valid,
    input wire logic [ptkts_pkg::TIME_W-1:0] load_value,
    input wire logic adj_valid,
    input wire logic [ptkts_pkg::TIME_W-1:0] adj_delta,
    // current time
    output logic [ptkts_pkg::TIME_W-1:0] time_q
);
    logic [ptkts_pkg::TIME_W-1:0] step;
    logic [ptkts_pkg::TIME_W-1:0] delta;
    logic [ptkts_pkg::TIME_W-1:0] time_d;

    // adjust rides on top of the tick so no nanosecond is lost
    assign step = tick ? inc : '0;
    assign delta = adj_valid ? adj_delta : '0;
    assign time_d = load_valid ? load_value : time_q + step + delta;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            time_q <= ptkts_pkg::TIME_RESET;
        end else begin
            time_q <= time_d;
        end
    end

    a_load_wins: assert property (@(posedge core_clk) disable iff (rst)
        load_valid |=> time_q == $past(load_value))
        else $error("time keeper did not take the loaded value");

    a_adjust_applied: assert property (@(posedge core_clk) disable iff (rst)
        (adj_valid && !load_valid) |=> time_q == $past(time_q) + $past(step) + $past(adj_delta))
        else $error("time keeper lost an adjustment");
endmodule

// *** sim/ptkts_far_side.sv ***
// far-side model: chassis reference clock and grandmaster time corrections
// assumes the bench toggles ref_on just after a core_clk falling edge and calls send just after a rising edge
`timescale 1ns/1ps
module ptkts_far_side (
    // bench clock
    input wire logic core_clk,
    // reference control from the bench
    input wire logic ref_on,
    // towards the block
    output logic backplane_ref_clock,
    output ptkts_pkg::ptkts_cmd_type [ptkts_pkg::NUM_PORTS-1:0] gm_cmd
);
    // 10 mhz reference, phase unrelated to core_clk; held low while absent
    initial begin
        backplane_ref_clock = 1'b0;
        gm_cmd = '0;
        #13;
        forever begin
            #50;
            backplane_ref_clock = ref_on ? ~backplane_ref_clock : 1'b0;
        end
    end

    // grandmaster correction as a one-cycle pulse, like the sync firmware
    task send(input int p, input ptkts_pkg::ptkts_cmd_type c);
        gm_cmd[p] <= c;
        @(posedge core_clk);
        gm_cmd[p] <= '0;
    endtask
endmodule

// *** sim/ptkts_top_tb_top.sv ***
// self-checking bench for ptkts_top: time commands, reference switching, stamps
// assumes ptkts_far_side drives the reference pin and grandmaster commands
`timescale 1ns/1ps
module ptkts_top_tb_top;
    localparam int NP = ptkts_pkg::NUM_PORTS;
    localparam int TW = ptkts_pkg::TIME_W;

    // stimulus, each given a value at time zero
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ref_on = 1'b0;
    logic [ptkts_pkg::NUM_TRIG-1:0] trig_in = '0;
    logic [NP-1:0] rx_frame_start = '0;
    logic [NP-1:0] tx_frame_start = '0;
    logic [NP-1:0] monitor_en = '0;
    logic [NP-1:0] port_master = '0;
    ptkts_pkg::ptkts_cmd_type local_cmd = '0;
    ptkts_pkg::ptkts_cmd_type [NP-1:0] net_cmd = '0;
    // far side and design outputs
    ptkts_pkg::ptkts_cmd_type [NP-1:0] gm_cmd;
    logic backplane_ref_clock;
    logic ref_present_q;
    logic [TW-1:0] local_time_ns;
    logic [NP-1:0][TW-1:0] net_time_ns;
    ptkts_pkg::ptkts_stamp_type [NP-1:0] port_stamp_q;
    ptkts_pkg::ptkts_trig_type trig_stamp_q;
    // bookkeeping
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'hd67c;

    always #20 core_clk = ~core_clk;

    ptkts_top dut (.core_clk(core_clk), .rst(rst), .backplane_ref_clock(backplane_ref_clock), .trig_in(trig_in),
        .rx_frame_start(rx_frame_start), .tx_frame_start(tx_frame_start), .monitor_en(monitor_en),
        .port_master(port_master), .local_cmd(local_cmd), .net_cmd(net_cmd), .gm_cmd(gm_cmd),
        .ref_present_q(ref_present_q), .local_time_ns(local_time_ns), .net_time_ns(net_time_ns),
        .port_stamp_q(port_stamp_q), .trig_stamp_q(trig_stamp_q));

    ptkts_far_side far (.core_clk(core_clk), .ref_on(ref_on), .backplane_ref_clock(backplane_ref_clock),
        .gm_cmd(gm_cmd));

    // shift register sequence for random stimulus
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task check(input string what, input logic [TW-1:0] seen, input logic [TW-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one command pulse; oscillator mode, so the target gains 40 per cycle meanwhile
    task do_cmd(input int src, input int p, input logic ld, input logic adj, input logic [TW-1:0] v,
        input logic take_ld, input logic take_adj);
        ptkts_pkg::ptkts_cmd_type c;
        logic [TW-1:0] t0;
        logic [TW-1:0] exp;
        c = {ld, adj, v};
        @(negedge core_clk);
        t0 = (src == 0) ? local_time_ns : net_time_ns[p];
        exp = take_ld ? v : t0 + 64'h50 + (take_adj ? v : 64'h0);
        @(posedge core_clk);
        if (src == 2) begin
            far.send(p, c);
        end else begin
            if (src == 0) local_cmd <= c;
            else net_cmd[p] <= c;
            @(posedge core_clk);
            local_cmd <= '0;
            net_cmd <= '0;
        end
        @(negedge core_clk);
        check("time after command", (src == 0) ? local_time_ns : net_time_ns[p], exp);
    endtask

    // frame and trigger pins rise together; stamps appear two edges after the pins are first sampled
    task stamp(input int p, input logic rx, input logic tx, input logic mon, input logic [7:0] tm);
        logic [TW-1:0] tl;
        logic [NP-1:0][TW-1:0] tn;
        @(posedge core_clk);
        rx_frame_start[p] <= rx;
        tx_frame_start[p] <= tx;
        trig_in <= tm;
        monitor_en[p] <= mon;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        tl = local_time_ns;
        tn = net_time_ns;
        check("early valid", {port_stamp_q[p].rx_valid, port_stamp_q[p].tx_valid, trig_stamp_q.mask}, '0);
        @(negedge core_clk);
        check("rx valid", port_stamp_q[p].rx_valid, rx);
        check("tx valid", port_stamp_q[p].tx_valid, tx & mon);
        if (rx | tx) check("frame local", port_stamp_q[p].local_ns, tl);
        if (rx | tx) check("frame net", port_stamp_q[p].net_ns, tn[p]);
        check("trig mask", trig_stamp_q.mask, tm);
        if (tm != 8'h00) check("trig local", trig_stamp_q.local_ns, tl);
        for (int q = 0; q < NP; q++) if (tm != 8'h00) check("trig net", trig_stamp_q.net_ns[q], tn[q]);
        @(negedge core_clk);
        check("pulse width", {port_stamp_q[p].rx_valid, port_stamp_q[p].tx_valid, trig_stamp_q.mask}, '0);
        @(posedge core_clk);
        rx_frame_start <= '0;
        tx_frame_start <= '0;
        trig_in <= '0;
        repeat (3) @(posedge core_clk);
    endtask

    // main sequence
    initial begin
        int i;
        int q;
        logic [31:0] r;
        logic [TW-1:0] v;
        logic [TW-1:0] d;
        logic [TW-1:0] tl;
        logic [TW-1:0] dl;
        logic [TW-1:0] sum;
        logic [NP-1:0][TW-1:0] tn;
        repeat (3) @(posedge core_clk);
        check("reset time", local_time_ns, '0);
        r = rnd();
        rst <= 1'b0;
        port_master <= {r[3:2], 2'b01};
        monitor_en <= r[7:4];
        @(negedge core_clk);
        check("release time", local_time_ns, '0);
        @(negedge core_clk);
        check("first step", local_time_ns, 64'h28);
        $display("test reset done");
        // host load, adjust and load beating adjust in the same cycle
        for (i = 0; i < 4; i++) begin
            v = {rnd(), rnd()};
            r = rnd();
            d = {{32{r[31]}}, r};
            do_cmd(0, 0, 1'b1, 1'b0, v, 1'b1, 1'b0);
            do_cmd(0, 0, 1'b0, 1'b1, d, 1'b0, 1'b1);
            do_cmd(0, 0, 1'b1, 1'b1, v ^ d, 1'b1, 1'b0);
        end
        $display("test local commands done");
        // per-port sources: host loads masters, grandmaster loads slaves, host adjusts any port, grandmaster adjusts slaves only
        for (q = 0; q < NP; q++) begin
            v = {rnd(), rnd()};
            r = rnd();
            d = {{32{r[31]}}, r};
            do_cmd(1, q, 1'b1, 1'b0, v, port_master[q], 1'b0);
            do_cmd(2, q, 1'b1, 1'b0, ~v, !port_master[q], 1'b0);
            do_cmd(1, q, 1'b0, 1'b1, d, 1'b0, 1'b1);
            do_cmd(2, q, 1'b0, 1'b1, d, 1'b0, !port_master[q]);
        end
        $display("test network commands done");
        // reference present: 100 per edge, masters follow local, slaves keep 40 per cycle
        ref_on = 1'b1;
        for (i = 0; i < 20 && ref_present_q !== 1'b1; i++) @(negedge core_clk);
        if (ref_present_q !== 1'b1) begin
            n_errors++;
            conclude();
        end
        repeat (4) @(negedge core_clk);
        tl = local_time_ns;
        tn = net_time_ns;
        sum = '0;
        for (i = 0; i < 40; i++) begin
            @(negedge core_clk);
            dl = local_time_ns - tl;
            sum = sum + dl;
            check("ref step", (dl == 64'h0 || dl == 64'h64), 1'b1);
            check("presence", ref_present_q, 1'b1);
            for (q = 0; q < NP; q++) check("net step", net_time_ns[q] - tn[q], port_master[q] ? dl : 64'h28);
            tl = local_time_ns;
            tn = net_time_ns;
        end
        check("ref rate", (sum >= 64'h5dc && sum <= 64'h6a4), 1'b1);
        // reference removed: presence drops and the oscillator takes over
        ref_on = 1'b0;
        repeat (16) @(negedge core_clk);
        check("absence", ref_present_q, 1'b0);
        tl = local_time_ns;
        @(negedge core_clk);
        check("osc step", local_time_ns - tl, 64'h28);
        $display("test reference switch done");
        // every trigger line alone, then random mixes; the last pass sends an unmonitored transmit frame
        for (i = 0; i < 15; i++) begin
            r = rnd();
            if (i == 14) r[4] = 1'b0;
            stamp(r[1:0], r[2] | (i == 13), r[3] | (i >= 13), r[4], (i < 8) ? (8'h01 << i) : r[15:8]);
        end
        $display("test stamps done");
        conclude();
    end
endmodule
